// *** rtl/ccsel_regs.svh ***
/*
  constants for the cpu clock select and oscillator watchdog block.
  assumes inclusion by bare name from the design files.
*/
`ifndef CCSEL_REGS_SVH
`define CCSEL_REGS_SVH
`define CCSEL_MODE_W 3
`define CCSEL_MODE_X4 3'h7
`define CCSEL_MODE_X3 3'h6
`define CCSEL_MODE_X2 3'h5
`define CCSEL_MODE_X5 3'h4
`define CCSEL_MODE_DIRECT 3'h3
`define CCSEL_MODE_X1P5 3'h2
`define CCSEL_MODE_DIV2 3'h1
`define CCSEL_MODE_X2P5 3'h0
`define CCSEL_WD_CNT_W 5
`define CCSEL_WD_OVF 5'h10
`define CCSEL_WD_ZERO 5'h00
`define CCSEL_WD_DISABLE_BIT 4
`define CCSEL_PH_W 4
`define CCSEL_PH_ZERO 4'h0
`define CCSEL_PH_ONE 4'h1
`define CCSEL_FRAC_ZERO 2'h0
`endif

// *** rtl/ccsel_pkg.sv ***
/*
  types for the cpu clock select block.
  assumes nothing of its surroundings.
*/
package ccsel_pkg;
  typedef enum logic [1:0] {CCSEL_SRC_PLL, CCSEL_SRC_DIRECT, CCSEL_SRC_DIV2, CCSEL_SRC_FREE} ccsel_src_e;
  typedef logic [2:0] ccsel_mode_t;
endpackage : ccsel_pkg

// *** rtl/ccsel_edge_sync.sv ***
/*
  three-flop synchroniser with edge detect for the oscillator input pin.
  assumes an asynchronous input; a change counts when stages two and three agree.
*/
`timescale 1ns/10ps
module ccsel_edge_sync (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic asyncIn,
  output logic level,
  output logic anyEdge,
  output logic riseEdge
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= asyncIn;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
  // edge counts once stages two and three agree on a new level
  assign anyEdge = (s2 == s3) && (s3 != level);
  assign riseEdge = anyEdge && s3;
endmodule : ccsel_edge_sync

// *** rtl/ccsel_clock_select.sv ***
/*
  cpu clock generation: strap-selected pll multiply, direct drive or 2:1 prescale,
  plus oscillator watchdog with permanent switchover to the free-running clock.
  assumes core_clk stands for the pll free-running clock and the pll multiplier;
  the oscillator input arrives asynchronously on oscInputPin.
*/
`timescale 1ns/10ps
`include "ccsel_regs.svh"
module ccsel_clock_select (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic oscInputPin,
  input wire logic [2:0] clockModeStrapPins,
  input wire logic [7:0] systemConfigReg,
  input wire logic oscFailIrqClear,
  output logic cpuClk,
  output logic cpuClkEdge,
  output logic [2:0] clockMode,
  output logic pllEnable,
  output logic oscWatchdogActive,
  output logic clockSwitched,
  output logic oscFailIrqFlag
);
  logic oscLevel;
  logic oscEdge;
  logic oscRise;
  logic strapHeld;
  logic [2:0] strapSample;
  logic [`CCSEL_WD_CNT_W-1:0] wdCount;
  logic [`CCSEL_PH_W-1:0] phase;
  logic [`CCSEL_PH_W-1:0] halfLen;
  logic [2:0] strapSync1;
  logic [2:0] strapSync2;
  logic [2:0] strapSync3;
  logic [`CCSEL_PH_W-1:0] edgeCount;
  logic wdEnable;
  logic wdOverflow;
  ccsel_pkg::ccsel_src_e src;
  logic next_cpuClk;

  // free-running cycles per cpu half period for each multiply code
  function automatic logic [`CCSEL_PH_W-1:0] pll_half(input ccsel_pkg::ccsel_mode_t m);
    unique case (m)
      `CCSEL_MODE_X4: pll_half = 4'h2;
      `CCSEL_MODE_X3: pll_half = 4'h3;
      `CCSEL_MODE_X2: pll_half = 4'h4;
      `CCSEL_MODE_X5: pll_half = 4'h2;
      `CCSEL_MODE_X1P5: pll_half = 4'h5;
      `CCSEL_MODE_X2P5: pll_half = 4'h4;
      default: pll_half = 4'h1;
    endcase
  endfunction : pll_half

  // transitions of the input per resync: the integer factor, rounded up
  function automatic logic [`CCSEL_PH_W-1:0] pll_factor(input ccsel_pkg::ccsel_mode_t m);
    unique case (m)
      `CCSEL_MODE_X4: pll_factor = 4'h4;
      `CCSEL_MODE_X3: pll_factor = 4'h3;
      `CCSEL_MODE_X2: pll_factor = 4'h2;
      `CCSEL_MODE_X5: pll_factor = 4'h5;
      `CCSEL_MODE_X1P5: pll_factor = 4'h2;
      `CCSEL_MODE_X2P5: pll_factor = 4'h3;
      default: pll_factor = 4'h1;
    endcase
  endfunction : pll_factor

  function automatic logic is_osc_mode(input ccsel_pkg::ccsel_mode_t m);
    is_osc_mode = (m == `CCSEL_MODE_DIRECT) || (m == `CCSEL_MODE_DIV2);
  endfunction : is_osc_mode

  ccsel_edge_sync u_osc_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(oscInputPin),
    .level(oscLevel),
    .anyEdge(oscEdge),
    .riseEdge(oscRise)
  );

  // strap pins pass three flops; a level counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    strapSync1 <= clockModeStrapPins;
    strapSync2 <= strapSync1;
    strapSync3 <= strapSync2;
  end

  // strap sampling: follow pins during reset, freeze at release
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      if (strapSync2 == strapSync3) begin
        strapSample <= strapSync3;
      end
      strapHeld <= 1'b0;
    end else begin
      strapHeld <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      clockMode <= `CCSEL_MODE_X4;
    end else if (!strapHeld) begin
      clockMode <= strapSample;
    end
  end

  assign wdEnable = !systemConfigReg[`CCSEL_WD_DISABLE_BIT];
  assign halfLen = pll_half(clockMode);
  assign wdOverflow = (wdCount == `CCSEL_WD_OVF);

  // oscillator watchdog counter
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wdCount <= `CCSEL_WD_ZERO;
    end else if (!wdEnable || !is_osc_mode(clockMode) || !strapHeld || oscEdge) begin
      wdCount <= `CCSEL_WD_ZERO;
    end else if (!wdOverflow) begin
      wdCount <= wdCount + 5'h01;
    end
  end

  // clock source selection; switchover is sticky
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      clockSwitched <= 1'b0;
    end else if (wdOverflow && wdEnable && is_osc_mode(clockMode)) begin
      clockSwitched <= 1'b1;
    end
  end

  always_comb begin
    if (clockSwitched) begin
      src = ccsel_pkg::CCSEL_SRC_FREE;
    end else if (clockMode == `CCSEL_MODE_DIRECT) begin
      src = ccsel_pkg::CCSEL_SRC_DIRECT;
    end else if (clockMode == `CCSEL_MODE_DIV2) begin
      src = ccsel_pkg::CCSEL_SRC_DIV2;
    end else begin
      src = ccsel_pkg::CCSEL_SRC_PLL;
    end
  end

  // fail flag: set wins over clear
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      oscFailIrqFlag <= 1'b0;
    end else if (wdOverflow && wdEnable && is_osc_mode(clockMode) && !clockSwitched) begin
      oscFailIrqFlag <= 1'b1;
    end else if (oscFailIrqClear) begin
      oscFailIrqFlag <= 1'b0;
    end
  end

  // pll half-period phase, resynchronised every factor-count input transitions
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      edgeCount <= `CCSEL_PH_ZERO;
    end else if (src != ccsel_pkg::CCSEL_SRC_PLL) begin
      edgeCount <= `CCSEL_PH_ZERO;
    end else if (oscEdge) begin
      if (edgeCount + `CCSEL_PH_ONE >= pll_factor(clockMode)) begin
        edgeCount <= `CCSEL_PH_ZERO;
      end else begin
        edgeCount <= edgeCount + `CCSEL_PH_ONE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      phase <= `CCSEL_PH_ZERO;
    end else if (src == ccsel_pkg::CCSEL_SRC_PLL && oscEdge && edgeCount == `CCSEL_PH_ZERO
                 && phase > (halfLen >> 1)) begin
      phase <= phase - `CCSEL_PH_ONE;
    end else if (phase + `CCSEL_PH_ONE >= halfLen) begin
      phase <= `CCSEL_PH_ZERO;
    end else begin
      phase <= phase + `CCSEL_PH_ONE;
    end
  end

  always_comb begin
    next_cpuClk = cpuClk;
    unique case (src)
      ccsel_pkg::CCSEL_SRC_DIRECT: next_cpuClk = oscLevel;
      ccsel_pkg::CCSEL_SRC_DIV2: next_cpuClk = oscRise ? !cpuClk : cpuClk;
      ccsel_pkg::CCSEL_SRC_FREE: next_cpuClk = !cpuClk;
      ccsel_pkg::CCSEL_SRC_PLL: begin
        if (phase + `CCSEL_PH_ONE >= halfLen) begin
          next_cpuClk = !cpuClk;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cpuClk <= 1'b0;
      cpuClkEdge <= 1'b0;
    end else begin
      cpuClk <= next_cpuClk;
      cpuClkEdge <= next_cpuClk != cpuClk;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pllEnable <= 1'b0;
      oscWatchdogActive <= 1'b0;
    end else begin
      // a switched clock runs from the pll, so it must stay powered
      pllEnable <= !is_osc_mode(clockMode) || wdEnable || clockSwitched;
      oscWatchdogActive <= is_osc_mode(clockMode) && wdEnable && strapHeld;
    end
  end
endmodule : ccsel_clock_select

// *** verification/ccsel_clock_select_sva.sv ***
/*
  checker for the cpu clock select block, sees its ports only.
  assumes core_clk is the only clock and nrst a synchronous active-low reset.
*/
`timescale 1ns/10ps
`include "ccsel_regs.svh"
module ccsel_clock_select_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic oscInputPin,
  input wire logic [2:0] clockModeStrapPins,
  input wire logic [7:0] systemConfigReg,
  input wire logic oscFailIrqClear,
  input wire logic cpuClk,
  input wire logic cpuClkEdge,
  input wire logic [2:0] clockMode,
  input wire logic pllEnable,
  input wire logic oscWatchdogActive,
  input wire logic clockSwitched,
  input wire logic oscFailIrqFlag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [5:0] quiet;
  logic oscMode;
  assign oscMode = (clockMode == `CCSEL_MODE_DIRECT) || (clockMode == `CCSEL_MODE_DIV2);
  // cycles of running watchdog with no input change
  always_ff @(posedge core_clk) begin
    if (!nrst || !oscWatchdogActive || $changed(oscInputPin)) quiet <= 6'h00;
    else if (quiet != 6'h3f) quiet <= quiet + 6'h01;
  end
  a_mode_take: assert property (nrst && !$past(nrst) |=>
    clockMode == $past(clockModeStrapPins, 5)) else $error("mode not taken from straps");
  a_mode_hold: assert property ($past(nrst) && $past(nrst, 2) |->
    $stable(clockMode)) else $error("mode changed after reset");
  a_pll_nowd: assert property ($past(nrst, 2) && !oscMode |->
    !oscWatchdogActive && !clockSwitched) else $error("watchdog active in pll mode");
  a_wd_off: assert property (oscMode && systemConfigReg[`CCSEL_WD_DISABLE_BIT] &&
    !clockSwitched |=>
    !oscWatchdogActive && !pllEnable) else $error("disabled watchdog still running");
  a_ovf_switch: assert property (quiet == 6'h18 |-> clockSwitched)
    else $error("no switchover after lost input");
  a_no_early: assert property ($rose(clockSwitched) |-> quiet >= 6'h10)
    else $error("switchover before overflow");
  a_sw_flag: assert property ($rose(clockSwitched) |-> oscFailIrqFlag)
    else $error("fail flag not set on switchover");
  a_sw_sticky: assert property (clockSwitched |=> clockSwitched)
    else $error("switchover reverted");
  a_flag_hold: assert property (oscFailIrqFlag && !oscFailIrqClear |=> oscFailIrqFlag)
    else $error("fail flag dropped without clear");
  a_free_toggle: assert property ($past(clockSwitched) |-> cpuClk != $past(cpuClk))
    else $error("free-running clock not toggling");
  a_edge_mark: assert property (cpuClkEdge == (cpuClk != $past(cpuClk)))
    else $error("edge mark does not match clock toggle");
  cover property ($rose(clockSwitched));
  cover property (oscFailIrqFlag && oscFailIrqClear);
  cover property (oscMode && systemConfigReg[`CCSEL_WD_DISABLE_BIT]);
endmodule : ccsel_clock_select_chk
bind ccsel_clock_select ccsel_clock_select_chk chk (.core_clk(core_clk), .nrst(nrst),
  .oscInputPin(oscInputPin), .clockModeStrapPins(clockModeStrapPins),
  .systemConfigReg(systemConfigReg), .oscFailIrqClear(oscFailIrqClear), .cpuClk(cpuClk),
  .cpuClkEdge(cpuClkEdge), .clockMode(clockMode), .pllEnable(pllEnable),
  .oscWatchdogActive(oscWatchdogActive), .clockSwitched(clockSwitched),
  .oscFailIrqFlag(oscFailIrqFlag));

// *** verification/ccsel_osc_model.sv ***
/*
  external oscillator source model.
  assumes the bench sets run and the half period in ns.
*/
`timescale 1ns/10ps
module ccsel_osc_model (
  input wire logic run,
  input wire logic [7:0] halfNs,
  output logic osc
);
  initial osc = 1'b0;
  // a stopped source holds its last level
  always begin
    #((halfNs > 8'h00) ? halfNs : 20);
    if (run) osc = ~osc;
  end
endmodule : ccsel_osc_model

// *** verification/tb.sv ***
/*
  self-checking bench for the cpu clock select block.
  assumes the oscillator model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
`include "ccsel_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errCount++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module tb;
  logic core_clk, nrst, oscRun, oscIn, clr, cpuClk, cpuEdge, pllEn, wdAct, sw, flag;
  logic [2:0] strap, mode;
  logic [7:0] cfg, halfNs;
  int errCount, checked, seed, n, e, t, r;
  ccsel_osc_model osc (.run(oscRun), .halfNs(halfNs), .osc(oscIn));
  ccsel_clock_select DUT (.core_clk(core_clk), .nrst(nrst), .oscInputPin(oscIn),
    .clockModeStrapPins(strap), .systemConfigReg(cfg), .oscFailIrqClear(clr),
    .cpuClk(cpuClk), .cpuClkEdge(cpuEdge), .clockMode(mode), .pllEnable(pllEn),
    .oscWatchdogActive(wdAct), .clockSwitched(sw), .oscFailIrqFlag(flag));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic logic osc_mode(input logic [2:0] c);
    return (c == `CCSEL_MODE_DIRECT) || (c == `CCSEL_MODE_DIV2);
  endfunction : osc_mode
  task automatic close_out();
    $display("errors %0d checks %0d", errCount, checked);
    if (errCount == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic boot(input logic [2:0] c, input logic dis);
    @(negedge core_clk);
    nrst = 1'b0;
    strap = c;
    cfg = 8'($random(seed));
    cfg[`CCSEL_WD_DISABLE_BIT] = dis;
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    repeat (3) @(negedge core_clk);
    strap = 3'($random(seed));
  endtask : boot
  task automatic tick(input int k);
    repeat (k) @(negedge core_clk);
  endtask : tick
  // counts cpu clock toggles, input toggles and input rises over k cycles
  task automatic watch(input int k, output int ne, output int nt, output int nr);
    logic prev;
    ne = 0;
    nt = 0;
    nr = 0;
    prev = oscIn;
    repeat (k) begin
      @(negedge core_clk);
      if (cpuEdge === 1'b1) ne++;
      if (oscIn !== prev) begin
        nt++;
        if (oscIn === 1'b1) nr++;
      end
      prev = oscIn;
    end
  endtask : watch
  initial begin
    seed = 43384;
    nrst = 1'b0;
    strap = 3'h7;
    cfg = 8'h00;
    oscRun = 1'b1;
    halfNs = 8'h1e;
    clr = 1'b0;
    for (int i = 0; i < 8; i++) begin
      halfNs = 8'h14 + 8'({$random(seed)} % 60);
      oscRun = 1'b1;
      boot(i[2:0], 1'b0);
      tick(60);
      `CHK(mode, i[2:0])
      `CHK(sw, 1'b0)
      `CHK(wdAct, osc_mode(i[2:0]))
      if (!osc_mode(i[2:0])) `CHK(pllEn, 1'b1)
      watch(100, e, t, r);
      if (i[2:0] == `CCSEL_MODE_DIRECT) `CHK((e + 2 >= t) && (t + 2 >= e), 1'b1)
      else if (i[2:0] == `CCSEL_MODE_DIV2) `CHK((e + 2 >= r) && (r + 2 >= e), 1'b1)
      else `CHK(e >= 16, 1'b1)
      oscRun = 1'b0;
      if (osc_mode(i[2:0])) begin
        n = 0;
        while (sw !== 1'b1 && n < 100) begin
          tick(1);
          n++;
        end
        if (n == 100) begin
          errCount++;
          close_out();
        end
        `CHK(flag, 1'b1)
        watch(16, e, t, r);
        `CHK(e, 16)
        oscRun = 1'b1;
        tick(40);
        `CHK(sw, 1'b1)
        `CHK(flag, 1'b1)
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        tick(1);
        `CHK(flag, 1'b0)
        boot(i[2:0], 1'b1);
        oscRun = 1'b0;
        tick(60);
        `CHK(sw, 1'b0)
        `CHK(pllEn, 1'b0)
        if (i[2:0] == `CCSEL_MODE_DIRECT) `CHK(cpuClk, oscIn)
        else `CHK(cpuEdge, 1'b0)
      end else begin
        tick(60);
        `CHK(sw, 1'b0)
      end
    end
    close_out();
  end
endmodule : tb
